//--- lspc_regs.svh
// Register offsets, field positions, reset values and timing counts of the calibration controller.
`ifndef LSPC_REGS_SVH
`define LSPC_REGS_SVH

// ==========================================================================
// Device-side register map
// ==========================================================================
`define LSPC_DEV_SMP_ADDR     8'h05
`define LSPC_DEV_PRB_ADDR     8'h04
`define LSPC_DEV_RES_ADDR     8'h06
`define LSPC_RES_BIT          0
`define LSPC_SETUP_LSB        4
`define LSPC_HOLD_LSB         0
`define LSPC_SMP_LAST         5'h1f
`define LSPC_STEP_MAX         4'hf
`define LSPC_MIN_SUM          5'h08
`define LSPC_TEMP_LIMIT       8'h14

// ==========================================================================
// Own register map on APB
// ==========================================================================
`define LSPC_CTRL_OFS         8'h00
`define LSPC_STAT_OFS         8'h04
`define LSPC_TEMP_OFS         8'h08
`define LSPC_DRIFT_OFS        8'h0c
`define LSPC_ENTRY_OFS        8'h10
`define LSPC_CTRL_START       0
`define LSPC_CTRL_FAST        1
`define LSPC_CTRL_HIRATE      2
`define LSPC_CTRL_RST         2'h0

// ==========================================================================
// Timing
// ==========================================================================
`define LSPC_CLK_NS           100
`define LSPC_SETTLE_NS        400
`define LSPC_SETTLE_CYC       ((`LSPC_SETTLE_NS + `LSPC_CLK_NS - 1) / `LSPC_CLK_NS)

`endif

//--- lspc_pkg.sv
// Types shared by the calibration controller modules.
package lspc_pkg;

	// Main sequencer states, one-hot.
	typedef enum logic [7:0] {
		ST_IDLE   = 8'h01,
		ST_WR_SMP = 8'h02,
		ST_WR_PRB = 8'h04,
		ST_SETTLE = 8'h08,
		ST_RD     = 8'h10,
		ST_EVAL   = 8'h20,
		ST_SCAN   = 8'h40,
		ST_PICK   = 8'h80
	} lspc_state_t;

	// What the current probe read is for.
	typedef enum logic [5:0] {
		PH_BASE  = 6'h01,
		PH_HOLD  = 6'h02,
		PH_SETUP = 6'h04,
		PH_VHI   = 6'h08,
		PH_VLO   = 6'h10,
		PH_FINAL = 6'h20
	} lspc_phase_t;

endpackage

//--- lspc_dev_port.sv
// Four-phase handshake engine toward the device's register interface.
`timescale 1ns/10ps
`include "lspc_regs.svh"

module lspc_dev_port
(
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       cmd_valid_i,
	input  wire logic       cmd_we_i,
	input  wire logic [7:0] cmd_addr_i,
	input  wire logic [7:0] cmd_wdata_i,
	output logic            cmd_done_o,
	output logic [7:0]      cmd_rdata_o,
	output logic            dev_req_o,
	output logic            dev_we_o,
	output logic [7:0]      dev_addr_o,
	output logic [7:0]      dev_wdata_o,
	input  wire logic       dev_ack_i,
	input  wire logic [7:0] dev_rdata_i
);

	logic       ack_s1_reg;
	logic       ack_s2_reg;
	logic [7:0] rd_s1_reg;
	logic [7:0] rd_s2_reg;
	logic       wait_low_reg;

	// ======================================================================
	// Synchronisers
	// ======================================================================
	// Read data travels beside ack; it is stable while ack is high, so two
	// flops per bit are enough and no bit can be caught mid-change.
	always_ff @(posedge clk_i)
	begin
		ack_s1_reg <= dev_ack_i;
		ack_s2_reg <= ack_s1_reg;
		rd_s1_reg  <= dev_rdata_i;
		rd_s2_reg  <= rd_s1_reg;
	end

	// ======================================================================
	// Handshake
	// ======================================================================
	// Request rises on a command, falls on synced ack, and done pulses once
	// ack has fallen again, so back-to-back commands never overlap.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			dev_req_o    <= 1'b0;
			dev_we_o     <= 1'b0;
			dev_addr_o   <= 8'h00;
			dev_wdata_o  <= 8'h00;
			wait_low_reg <= 1'b0;
			cmd_done_o   <= 1'b0;
			cmd_rdata_o  <= 8'h00;
		end
		else
		begin
			cmd_done_o <= 1'b0;
			if (cmd_valid_i && !dev_req_o && !wait_low_reg)
			begin
				dev_req_o   <= 1'b1;
				dev_we_o    <= cmd_we_i;
				dev_addr_o  <= cmd_addr_i;
				dev_wdata_o <= cmd_wdata_i;
			end
			else if (dev_req_o && ack_s2_reg)
			begin
				dev_req_o    <= 1'b0;
				wait_low_reg <= 1'b1;
				cmd_rdata_o  <= rd_s2_reg;
			end
			else if (wait_low_reg && !ack_s2_reg)
			begin
				wait_low_reg <= 1'b0;
				cmd_done_o   <= 1'b1;
			end
		end
	end

endmodule

//--- lspc_cal_ctrl.sv
// Sample-point calibration controller: sweeps device delays, builds the array, picks the point.
//
// Chosen here: the address map and the APB slave port.
`timescale 1ns/10ps
`include "lspc_regs.svh"

module lspc_cal_ctrl
#(
	parameter int SETTLE_CYC = `LSPC_SETTLE_CYC
)
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic [31:0]      prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	output logic             dev_req_o,
	output logic             dev_we_o,
	output logic [7:0]       dev_addr_o,
	output logic [7:0]       dev_wdata_o,
	input  wire logic        dev_ack_i,
	input  wire logic [7:0]  dev_rdata_i,
	output logic             cal_active_o
);

	// Timing array, one entry per sample delay.
	logic                 probe_mem [0:31];
	logic [3:0]           setup_mem [0:31];
	logic [3:0]           hold_mem  [0:31];

	lspc_pkg::lspc_state_t state_reg;
	lspc_pkg::lspc_phase_t phase_reg;
	logic [4:0]           smp_reg;
	logic [3:0]           step_reg;
	logic                 base_reg;
	logic [3:0]           wait_reg;
	logic                 issue_reg;
	logic                 fast_reg;
	logic                 hirate_reg;
	logic                 rerun_reg;
	logic                 done_reg;
	logic                 margin_ok_reg;
	logic                 suspect_reg;
	logic                 nowin_reg;
	logic [4:0]           chosen_sample_delay;
	logic                 rise_reg;
	logic                 fall_reg;
	logic [4:0]           rise_idx_reg;
	logic [4:0]           fall_idx_reg;
	logic                 best_ok_reg;
	logic [4:0]           best_idx_reg;
	logic [3:0]           best_diff_reg;
	logic [4:0]           entry_reg;

	// Absolute difference of two probe delays.
	function automatic logic [3:0] absdiff4(input logic [3:0] a, input logic [3:0] b);
		absdiff4 = (a > b) ? (a - b) : (b - a);
	endfunction

	// ======================================================================
	// APB decode
	// ======================================================================
	wire        apb_acc   = psel_i && penable_i && !pready_o;
	// Writes commit at the completing edge, the one at which the master sees ready.
	wire        apb_wr    = psel_i && penable_i && pready_o && pwrite_i;
	wire        hit_ctrl  = paddr_i == `LSPC_CTRL_OFS;
	wire        hit_stat  = paddr_i == `LSPC_STAT_OFS;
	wire        hit_temp  = paddr_i == `LSPC_TEMP_OFS;
	wire        hit_drift = paddr_i == `LSPC_DRIFT_OFS;
	wire        hit_entry = paddr_i == `LSPC_ENTRY_OFS;
	wire        hit_any   = hit_ctrl | hit_stat | hit_temp | hit_drift | hit_entry;
	wire        start_wr  = apb_wr && hit_ctrl && pwdata_i[`LSPC_CTRL_START];
	wire [3:0]  ch_set    = setup_mem[chosen_sample_delay];
	wire [3:0]  ch_hold   = hold_mem[chosen_sample_delay];
	wire [3:0]  ch_min    = (ch_set < ch_hold) ? ch_set : ch_hold;
	// A new temperature excursion only matters above the uptime-safe rate.
	wire        temp_hit  = apb_wr && hit_temp && hirate_reg && done_reg
	                        && (pwdata_i[7:0] > `LSPC_TEMP_LIMIT);
	wire        drift_hit = apb_wr && hit_drift && done_reg
	                        && ({pwdata_i[7:0], 2'b00} > {6'h00, ch_min});
	wire [31:0] stat_word = {19'h00000, chosen_sample_delay, 3'b000, nowin_reg, suspect_reg,
	                         margin_ok_reg, done_reg, cal_active_o};
	wire [31:0] entry_word = {15'h0000, probe_mem[entry_reg], 4'h0, setup_mem[entry_reg],
	                          4'h0, hold_mem[entry_reg]};
	wire [31:0] rd_word   = hit_ctrl  ? {29'h0, hirate_reg, fast_reg, 1'b0} :
	                        hit_stat  ? stat_word :
	                        hit_entry ? {19'h0, entry_reg, 8'h00} | entry_word :
	                        32'h0;

	// ======================================================================
	// APB slave registers
	// ======================================================================
	// One wait state: pready is raised in the second access cycle so that
	// read data can come from a flop like every other output.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			pready_o   <= 1'b0;
			pslverr_o  <= 1'b0;
			prdata_o   <= 32'h0;
			fast_reg   <= 1'b0;
			hirate_reg <= 1'b0;
			entry_reg  <= 5'h00;
		end
		else
		begin
			pready_o  <= apb_acc;
			pslverr_o <= apb_acc && !hit_any;
			prdata_o  <= (apb_acc && !pwrite_i) ? rd_word : 32'h0;
			if (apb_wr && hit_ctrl)
			begin
				fast_reg   <= pwdata_i[`LSPC_CTRL_FAST];
				hirate_reg <= pwdata_i[`LSPC_CTRL_HIRATE];
			end
			if (apb_wr && hit_entry)
			begin
				entry_reg <= pwdata_i[12:8];
			end
		end
	end

	// ======================================================================
	// Device command selection
	// ======================================================================
	wire        ph_ver    = phase_reg == lspc_pkg::PH_VHI || phase_reg == lspc_pkg::PH_VLO;
	wire [4:0]  smp_val   = (phase_reg == lspc_pkg::PH_VHI)   ? chosen_sample_delay + 5'h01 :
	                        (phase_reg == lspc_pkg::PH_VLO)   ? chosen_sample_delay - 5'h01 :
	                        (phase_reg == lspc_pkg::PH_FINAL) ? chosen_sample_delay :
	                        smp_reg;
	wire [7:0]  prb_val   = (phase_reg == lspc_pkg::PH_HOLD)  ? {4'h0, step_reg} :
	                        (phase_reg == lspc_pkg::PH_SETUP) ? {step_reg, 4'h0} :
	                        8'h00;
	wire        is_wr     = state_reg != lspc_pkg::ST_RD;
	wire [7:0]  cmd_addr  = (state_reg == lspc_pkg::ST_WR_SMP) ? `LSPC_DEV_SMP_ADDR :
	                        (state_reg == lspc_pkg::ST_WR_PRB) ? `LSPC_DEV_PRB_ADDR :
	                        `LSPC_DEV_RES_ADDR;
	wire [7:0]  cmd_wdata = (state_reg == lspc_pkg::ST_WR_SMP) ? {3'h0, smp_val} : prb_val;
	wire        cmd_done;
	wire [7:0]  cmd_rdata;
	wire        res_bit   = cmd_rdata[`LSPC_RES_BIT];
	wire        flipped   = res_bit != base_reg;
	wire        search_end = flipped || step_reg == `LSPC_STEP_MAX;
	// A neighbour that does not exist cannot show margin.
	wire        edge_bad  = (phase_reg == lspc_pkg::PH_VHI && chosen_sample_delay == 5'h1f)
	                        || (phase_reg == lspc_pkg::PH_VLO && chosen_sample_delay == 5'h00);

	lspc_dev_port u_port
	(
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.cmd_valid_i (issue_reg),
		.cmd_we_i    (is_wr),
		.cmd_addr_i  (cmd_addr),
		.cmd_wdata_i (cmd_wdata),
		.cmd_done_o  (cmd_done),
		.cmd_rdata_o (cmd_rdata),
		.dev_req_o   (dev_req_o),
		.dev_we_o    (dev_we_o),
		.dev_addr_o  (dev_addr_o),
		.dev_wdata_o (dev_wdata_o),
		.dev_ack_i   (dev_ack_i),
		.dev_rdata_i (dev_rdata_i)
	);

	// ======================================================================
	// Window scan terms
	// ======================================================================
	wire [4:0]  scan_i    = smp_reg;
	wire        cur_bit   = probe_mem[scan_i];
	wire        prev_bit  = probe_mem[scan_i - 5'h01];
	wire        rise_now  = !rise_reg && scan_i != 5'h00 && !prev_bit && cur_bit;
	wire        fall_now  = rise_reg && !fall_reg && prev_bit && !cur_bit;
	wire        in_win    = cur_bit && (rise_reg || rise_now) && !fall_reg;
	wire [3:0]  cur_diff  = absdiff4(hold_mem[scan_i], setup_mem[scan_i]);
	wire        better    = in_win && (setup_mem[scan_i] < hold_mem[scan_i])
	                        && (!best_ok_reg || cur_diff < best_diff_reg);
	wire [4:0]  win_end   = fall_reg ? fall_idx_reg - 5'h01 : `LSPC_SMP_LAST;
	wire [5:0]  win_sum   = {1'b0, rise_idx_reg} + {1'b0, win_end};
	wire [4:0]  centre    = win_sum[5:1];
	wire [4:0]  sum_sh    = {1'b0, ch_set} + {1'b0, ch_hold};

	// ======================================================================
	// Sequencer
	// ======================================================================
	// The device has no live margin monitor, so cal_active_o stays high
	// for the whole run and software must accept the gap.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_reg           <= lspc_pkg::ST_IDLE;
			phase_reg           <= lspc_pkg::PH_BASE;
			smp_reg             <= 5'h00;
			step_reg            <= 4'h0;
			base_reg            <= 1'b0;
			wait_reg            <= 4'h0;
			issue_reg           <= 1'b0;
			rerun_reg           <= 1'b0;
			done_reg            <= 1'b0;
			margin_ok_reg       <= 1'b0;
			suspect_reg         <= 1'b0;
			nowin_reg           <= 1'b0;
			chosen_sample_delay <= 5'h00;
			rise_reg            <= 1'b0;
			fall_reg            <= 1'b0;
			rise_idx_reg        <= 5'h00;
			fall_idx_reg        <= 5'h00;
			best_ok_reg         <= 1'b0;
			best_idx_reg        <= 5'h00;
			best_diff_reg       <= 4'h0;
			cal_active_o        <= 1'b0;
		end
		else
		begin
			// A rerun request raised during a run is lost: temp_hit and drift_hit need done_reg.
			rerun_reg <= temp_hit || drift_hit
			             || (rerun_reg && state_reg != lspc_pkg::ST_IDLE);
			issue_reg <= 1'b0;
			case (state_reg)
				lspc_pkg::ST_IDLE:
				begin
					if (start_wr || rerun_reg)
					begin
						state_reg     <= lspc_pkg::ST_WR_SMP;
						phase_reg     <= lspc_pkg::PH_BASE;
						smp_reg       <= 5'h00;
						done_reg      <= 1'b0;
						margin_ok_reg <= 1'b0;
						suspect_reg   <= 1'b0;
						nowin_reg     <= 1'b0;
						issue_reg     <= 1'b1;
						cal_active_o  <= 1'b1;
					end
				end
				lspc_pkg::ST_WR_SMP:
				begin
					if (cmd_done)
					begin
						state_reg <= lspc_pkg::ST_WR_PRB;
						issue_reg <= 1'b1;
					end
				end
				lspc_pkg::ST_WR_PRB:
				begin
					if (cmd_done)
					begin
						state_reg <= lspc_pkg::ST_SETTLE;
						wait_reg  <= 4'(SETTLE_CYC);
					end
				end
				lspc_pkg::ST_SETTLE:
				begin
					wait_reg <= wait_reg - 4'h1;
					if (wait_reg <= 4'h1)
					begin
						state_reg <= lspc_pkg::ST_RD;
						issue_reg <= 1'b1;
					end
				end
				lspc_pkg::ST_RD:
				begin
					if (cmd_done)
					begin
						state_reg <= lspc_pkg::ST_EVAL;
					end
				end
				lspc_pkg::ST_EVAL:
				begin
					state_reg <= lspc_pkg::ST_WR_PRB;
					issue_reg <= 1'b1;
					case (phase_reg)
						lspc_pkg::PH_BASE:
						begin
							base_reg           <= res_bit;
							probe_mem[smp_reg] <= res_bit;
							step_reg           <= 4'h1;
							if (!fast_reg)
							begin
								phase_reg <= lspc_pkg::PH_HOLD;
							end
							else if (smp_reg == `LSPC_SMP_LAST)
							begin
								state_reg <= lspc_pkg::ST_SCAN;
								issue_reg <= 1'b0;
								smp_reg   <= 5'h00;
							end
							else
							begin
								smp_reg   <= smp_reg + 5'h01;
								state_reg <= lspc_pkg::ST_WR_SMP;
							end
						end
						lspc_pkg::PH_HOLD:
						begin
							step_reg <= step_reg + 4'h1;
							if (search_end)
							begin
								hold_mem[smp_reg] <= step_reg;
								phase_reg         <= lspc_pkg::PH_SETUP;
								step_reg          <= 4'h1;
							end
						end
						lspc_pkg::PH_SETUP:
						begin
							step_reg <= step_reg + 4'h1;
							if (search_end)
							begin
								setup_mem[smp_reg] <= step_reg;
								phase_reg          <= lspc_pkg::PH_BASE;
								state_reg          <= lspc_pkg::ST_WR_SMP;
								if (smp_reg == `LSPC_SMP_LAST)
								begin
									state_reg <= lspc_pkg::ST_SCAN;
									issue_reg <= 1'b0;
									smp_reg   <= 5'h00;
								end
								else
								begin
									smp_reg <= smp_reg + 5'h01;
								end
							end
						end
						lspc_pkg::PH_VHI, lspc_pkg::PH_VLO:
						begin
							if (!res_bit || edge_bad)
							begin
								margin_ok_reg <= 1'b0;
							end
							phase_reg <= (phase_reg == lspc_pkg::PH_VHI) ? lspc_pkg::PH_VLO
							                                             : lspc_pkg::PH_FINAL;
							state_reg <= lspc_pkg::ST_WR_SMP;
						end
						default:
						begin
							state_reg    <= lspc_pkg::ST_IDLE;
							issue_reg    <= 1'b0;
							done_reg     <= 1'b1;
							cal_active_o <= 1'b0;
							suspect_reg  <= !fast_reg && sum_sh < `LSPC_MIN_SUM;
						end
					endcase
				end
				lspc_pkg::ST_SCAN:
				begin
					if (rise_now)
					begin
						rise_reg     <= 1'b1;
						rise_idx_reg <= scan_i;
					end
					if (fall_now)
					begin
						fall_reg     <= 1'b1;
						fall_idx_reg <= scan_i;
					end
					if (better)
					begin
						best_ok_reg   <= 1'b1;
						best_idx_reg  <= scan_i;
						best_diff_reg <= cur_diff;
					end
					smp_reg <= smp_reg + 5'h01;
					if (smp_reg == `LSPC_SMP_LAST)
					begin
						state_reg <= lspc_pkg::ST_PICK;
					end
				end
				lspc_pkg::ST_PICK:
				begin
					rise_reg    <= 1'b0;
					fall_reg    <= 1'b0;
					best_ok_reg <= 1'b0;
					if (!rise_reg || (!fast_reg && !best_ok_reg))
					begin
						nowin_reg    <= 1'b1;
						done_reg     <= 1'b1;
						cal_active_o <= 1'b0;
						state_reg    <= lspc_pkg::ST_IDLE;
					end
					else
					begin
						chosen_sample_delay <= fast_reg ? centre : best_idx_reg;
						margin_ok_reg       <= 1'b1;
						phase_reg           <= lspc_pkg::PH_VHI;
						state_reg           <= lspc_pkg::ST_WR_SMP;
						issue_reg           <= 1'b1;
					end
				end
				default:
				begin
					state_reg <= lspc_pkg::ST_IDLE;
				end
			endcase
		end
	end

endmodule

//--- lspc_cal_monitor.sv
// Port checker for the calibration controller.
`timescale 1ns/10ps
module lspc_cal_monitor
(
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [7:0]  paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] prdata_o,
	input wire logic        pready_o,
	input wire logic        pslverr_o,
	input wire logic        dev_req_o,
	input wire logic        dev_we_o,
	input wire logic [7:0]  dev_addr_o,
	input wire logic [7:0]  dev_wdata_o,
	input wire logic        dev_ack_i,
	input wire logic [7:0]  dev_rdata_i,
	input wire logic        cal_active_o
);
	// ==========
	// Properties
	// ==========
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// An access is taken in its first access cycle; an ack counts only mid-request.
	sequence s_taken;
		psel_i && penable_i && !pready_o;
	endsequence
	sequence s_ack_seen;
		dev_req_o && $rose(dev_ack_i);
	endsequence
	AST_APB_ANSWER: assert property (s_taken |=> pready_o)
		else $error("access not answered one cycle after it was taken");
	AST_READY_PULSE: assert property (pready_o |=> !pready_o)
		else $error("ready stood longer than one cycle");
	AST_IDLE_DATA: assert property (!pready_o |-> prdata_o == 32'h0 && !pslverr_o)
		else $error("read data or error outside a completion");
	AST_UNMAPPED: assert property (pready_o && paddr_i > 8'h10 |-> pslverr_o)
		else $error("unmapped address completed without error");
	AST_REQ_HOLD: assert property (dev_req_o && $past(dev_req_o) |->
		$stable(dev_addr_o) && $stable(dev_we_o) && $stable(dev_wdata_o))
		else $error("device request changed while raised");
	AST_DEV_ADDR: assert property (dev_req_o |-> dev_addr_o inside {8'h04, 8'h05, 8'h06})
		else $error("device request to a foreign register");
	AST_READ_RESULT: assert property (dev_req_o && !dev_we_o |-> dev_addr_o == 8'h06)
		else $error("device read not aimed at the probe result");
	AST_SMP_RANGE: assert property (dev_req_o && dev_we_o && dev_addr_o == 8'h05 |->
		dev_wdata_o[7:5] == 3'h0)
		else $error("sample delay out of range");
	AST_ONE_PROBE: assert property (dev_req_o && dev_we_o && dev_addr_o == 8'h04 |->
		dev_wdata_o[7:4] == 4'h0 || dev_wdata_o[3:0] == 4'h0)
		else $error("setup and hold probes raised together");
	AST_REQ_DROP: assert property (s_ack_seen |-> ##[1:4] !dev_req_o)
		else $error("request not dropped after acknowledge");
	AST_NEW_REQ: assert property ($rose(dev_req_o) |-> !dev_ack_i && $past(dev_ack_i, 2) == 1'b0)
		else $error("request raised before acknowledge settled low");
	AST_ACTIVE_REQ: assert property (dev_req_o |-> cal_active_o)
		else $error("device traffic while not calibrating");
endmodule

bind lspc_cal_ctrl lspc_cal_monitor u_mon
(
	.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
	.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
	.pready_o(pready_o), .pslverr_o(pslverr_o), .dev_req_o(dev_req_o), .dev_we_o(dev_we_o),
	.dev_addr_o(dev_addr_o), .dev_wdata_o(dev_wdata_o), .dev_ack_i(dev_ack_i),
	.dev_rdata_i(dev_rdata_i), .cal_active_o(cal_active_o)
);

//--- lspc_dev_model.sv
// Behavioural model of the converter's timing probe and its register port.
`timescale 1ns/10ps
module lspc_dev_model
#(
	parameter logic [31:0] WIN = 32'h0000_3f80
)
(
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       dev_req_i,
	input  wire logic       dev_we_i,
	input  wire logic [7:0] dev_addr_i,
	input  wire logic [7:0] dev_wdata_i,
	output logic            dev_ack_o,
	output logic [7:0]      dev_rdata_o
);
	// ==========
	// Probe
	// ==========
	logic [4:0] smp_reg;
	logic [7:0] prb_reg;
	logic [3:0] quiet_reg;
	logic [1:0] dly_reg;
	logic       slow_reg;
	// Thresholds move with the sample delay; the top quarter never flips at all.
	// One sample step is worth one probe step: setup needs one more, hold one less.
	wire [3:0]  k_w    = {1'b0, smp_reg[2:0]};
	wire        far_w  = (smp_reg[4:3] == 2'h3);
	wire        flip_w = !far_w && (prb_reg[3:0] >= 4'hb - k_w || prb_reg[7:4] >= k_w + 4'h2);
	wire        seek_w = WIN[smp_reg] ^ flip_w ^ (quiet_reg < 4'h2);

	// ==========
	// Register port
	// ==========
	// Answers alternate prompt and slow; read data goes stale once ack drops.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			dev_ack_o   <= 1'b0;
			dev_rdata_o <= 8'h5a;
			smp_reg     <= 5'h00;
			prb_reg     <= 8'h00;
			quiet_reg   <= 4'hf;
			dly_reg     <= 2'h0;
			slow_reg    <= 1'b0;
		end
		else
		begin
			if (quiet_reg != 4'hf)
				quiet_reg <= quiet_reg + 4'h1;
			if (dev_req_i && !dev_ack_o && dly_reg < {slow_reg, slow_reg})
				dly_reg <= dly_reg + 2'h1;
			else if (dev_req_i && !dev_ack_o)
			begin
				dev_ack_o <= 1'b1;
				dly_reg   <= 2'h0;
				slow_reg  <= !slow_reg;
				if (dev_we_i)
					quiet_reg <= 4'h0;
				if (dev_we_i && dev_addr_i == 8'h05)
					smp_reg <= dev_wdata_i[4:0];
				if (dev_we_i && dev_addr_i == 8'h04)
					prb_reg <= dev_wdata_i;
				dev_rdata_o <= (dev_addr_i == 8'h06) ? {7'h00, seek_w} : prb_reg;
			end
			else if (!dev_req_i && dev_ack_o)
			begin
				dev_ack_o   <= 1'b0;
				dev_rdata_o <= ~dev_rdata_o;
			end
		end
	end
endmodule

//--- tb.sv
// Self-checking bench for the calibration controller against the converter model.
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; \
	$display("unexpected at %0t: got %h expected %h", $time, (g), (e)); end end
module tb;
	// ==========
	// Signals
	// ==========
	localparam logic [31:0] WIN = 32'h0000_3f80;
	typedef struct {logic we; logic [7:0] a; logic [31:0] d; logic [31:0] e; logic er;} lspc_row_t;
	logic        clk_i, rst_i, psel_i, penable_i, pwrite_i;
	logic [7:0]  paddr_i, dev_addr_o, dev_wdata_o, dev_rdata_i;
	logic [31:0] pwdata_i, prdata_o, rd;
	logic        pready_o, pslverr_o, dev_req_o, dev_we_o, dev_ack_i, cal_active_o, er;
	int          err_count = 0;
	int          n_compared = 0;
	lspc_row_t   rows [11];

	lspc_cal_ctrl #(.SETTLE_CYC(2)) dut
	(
		.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
		.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
		.pready_o(pready_o), .pslverr_o(pslverr_o), .dev_req_o(dev_req_o), .dev_we_o(dev_we_o),
		.dev_addr_o(dev_addr_o), .dev_wdata_o(dev_wdata_o), .dev_ack_i(dev_ack_i),
		.dev_rdata_i(dev_rdata_i), .cal_active_o(cal_active_o)
	);
	lspc_dev_model #(.WIN(WIN)) u_dev
	(
		.clk_i(clk_i), .rst_i(rst_i), .dev_req_i(dev_req_o), .dev_we_i(dev_we_o),
		.dev_addr_i(dev_addr_o), .dev_wdata_i(dev_wdata_o), .dev_ack_o(dev_ack_i),
		.dev_rdata_o(dev_rdata_i)
	);

	// ==========
	// Helpers
	// ==========
	// Array entry as the model should leave it; setup shares bits 11:8 with the index.
	function automatic logic [31:0] entry_exp(input logic [4:0] i);
		logic [3:0] s;
		logic [3:0] h;
		s = (i[4:3] == 2'h3) ? 4'hf : {1'b0, i[2:0]} + 4'h2;
		h = (i[4:3] == 2'h3) ? 4'hf : 4'hb - {1'b0, i[2:0]};
		return {15'h0, WIN[i], 3'h0, i[4], i[3:0] | s, 4'h0, h};
	endfunction
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge clk_i);
		psel_i   <= 1'b1;
		pwrite_i <= w;
		paddr_i  <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		do
		begin
			@(posedge clk_i);
		end
		while (pready_o !== 1'b1);
		r = prdata_o;
		e = pslverr_o;
		psel_i    <= 1'b0;
		penable_i <= 1'b0;
	endtask
	// A rerun must show within a few cycles, so thirty is a generous bound.
	task automatic watch(input logic want);
		logic seen;
		seen = 1'b0;
		repeat (30) @(posedge clk_i) seen |= cal_active_o;
		`CHK(seen, want)
	endtask
	task automatic drain();
		int k;
		k = 0;
		while (cal_active_o !== 1'b0 && k < 40000)
		begin
			@(posedge clk_i);
			k++;
		end
		`CHK(cal_active_o, 1'b0)
	endtask
	task automatic end_sim();
		$display("compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// ==========
	// Stimulus
	// ==========
	initial
	begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	// Watchdog sized well above one full sweep plus the short runs.
	initial
	begin
		repeat (60000) @(posedge clk_i);
		err_count++;
		end_sim();
	end
	initial
	begin
		rst_i = 1'b1;
		psel_i = 1'b0;
		penable_i = 1'b0;
		pwrite_i = 1'b0;
		paddr_i = 8'h00;
		pwdata_i = 32'h0;
		rows[0] = '{1'b0, 8'h04, 32'h0, 32'h0000_0c06, 1'b0};
		rows[1] = '{1'b1, 8'h10, 32'h0000_0c00, 32'h0, 1'b0};
		rows[2] = '{1'b0, 8'h10, 32'h0, entry_exp(5'h0c), 1'b0};
		rows[3] = '{1'b1, 8'h10, 32'h0000_1800, 32'h0, 1'b0};
		rows[4] = '{1'b0, 8'h10, 32'h0, entry_exp(5'h18), 1'b0};
		rows[5] = '{1'b1, 8'h10, 32'h0000_0600, 32'h0, 1'b0};
		rows[6] = '{1'b0, 8'h10, 32'h0, entry_exp(5'h06), 1'b0};
		rows[7] = '{1'b1, 8'h14, 32'h1, 32'h0, 1'b1};
		rows[8] = '{1'b0, 8'h14, 32'h0, 32'h0, 1'b1};
		rows[9] = '{1'b1, 8'h00, 32'h4, 32'h0, 1'b0};
		rows[10] = '{1'b0, 8'h00, 32'h0, 32'h4, 1'b0};
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		`CHK({pready_o, dev_req_o, cal_active_o}, 3'h0)
		apb(1'b0, 8'h04, 32'h0, rd, er);
		`CHK(rd, 32'h0)
		apb(1'b1, 8'h00, 32'h1, rd, er);
		watch(1'b1);
		drain();
		foreach (rows[i])
		begin
			apb(rows[i].we, rows[i].a, rows[i].d, rd, er);
			`CHK({er, rd}, {rows[i].er, rows[i].e})
		end
		apb(1'b1, 8'h08, 32'h14, rd, er);
		watch(1'b0);
		apb(1'b1, 8'h0c, 32'h1, rd, er);
		watch(1'b0);
		apb(1'b1, 8'h0c, 32'h2, rd, er);
		watch(1'b1);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		`CHK({pready_o, dev_req_o, cal_active_o}, 3'h0)
		rst_i <= 1'b0;
		apb(1'b0, 8'h04, 32'h0, rd, er);
		`CHK(rd, 32'h0)
		apb(1'b1, 8'h00, 32'h3, rd, er);
		watch(1'b1);
		drain();
		apb(1'b0, 8'h04, 32'h0, rd, er);
		`CHK(rd & 32'h0000_1f02, 32'h0000_0a02)
		apb(1'b1, 8'h00, 32'h4, rd, er);
		apb(1'b1, 8'h08, 32'h15, rd, er);
		watch(1'b1);
		end_sim();
	end
endmodule
